// >>> hw/flash_command_sequencer.sv
// Host controller issuing flash command sequences and polling status
// What this block does
// - Flash drives data only on CE,OE low
// - Write needs WE low, CE low, OE high
// - Unlock pair then command; ident is 90
// - F0 alone or unlocked returns read mode
// - Program: unlock, A0, then address/data
// - Chip erase: unlock,80,unlock,10
// - Sector erase: unlock,80,unlock,30 at sector
// - B0 suspends sector erase, 30 resumes
`include "flash_host_consts.svh"
module flash_command_sequencer
	import flash_host_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Command request
	input wire logic cmdValid,
	input wire op_t cmdOp,
	input wire logic [`ADDR_W-1:0] cmdAddr,
	input wire logic [7:0] cmdData,
	output logic cmdReady,
	// Result
	output logic resultValid,
	output logic [7:0] resultData,
	output logic opDone,
	output logic opFailed,
	// Flash pins
	output logic chipEnableN,
	output logic outputEnableN,
	output logic writeEnableN,
	output logic [`ADDR_W-1:0] flashAddr,
	output logic [7:0] flashDataOut,
	output logic flashDataOe,
	input wire logic [7:0] flashDataIn
);
	////////////////////////////////////////////////////////////////////
	state_t state_r;
	op_t op_r;
	logic [2:0] step_r;
	logic [2:0] stepCount;
	logic [`ADDR_W-1:0] tgtAddr_r;
	logic [7:0] tgtData_r;
	logic [`ADDR_W-1:0] cycAddr;
	logic [7:0] cycData;
	logic cycWrite;
	logic cycStart_r;
	logic cycBusy;
	logic cycDone;
	logic [7:0] cycRdata;

	// Number of bus cycles per operation
	always_comb begin
		case (op_r)
			OP_PROGRAM: stepCount = 3'd4;
			OP_CHIP_ERASE: stepCount = 3'd6;
			OP_SECTOR_ERASE: stepCount = 3'd6;
			OP_RESET: stepCount = 3'd3;
			OP_IDENT: stepCount = 3'd3;
			default: stepCount = 3'd1;
		endcase
	end

	// Address and data of each step
	always_comb begin
		cycWrite = 1'b1;
		cycAddr = `UNLOCK_ADDR1;
		cycData = `UNLOCK_DATA1;
		case (op_r)
			OP_READ, OP_POLL: begin
				cycWrite = 1'b0;
				cycAddr = tgtAddr_r;
			end
			OP_SHORT_RESET: begin
				cycAddr = tgtAddr_r;
				cycData = `CMD_RESET;
			end
			OP_SUSPEND: begin
				cycAddr = tgtAddr_r;
				cycData = `CMD_SUSPEND;
			end
			OP_RESUME: begin
				cycAddr = tgtAddr_r;
				cycData = `CMD_RESUME;
			end
			OP_ADD_SECTOR: begin
				cycAddr = tgtAddr_r;
				cycData = `CMD_SECTOR_ERASE;
			end
			default: begin
				case (step_r)
					3'd0: begin
						cycAddr = `UNLOCK_ADDR1;
						cycData = `UNLOCK_DATA1;
					end
					3'd3: begin
						if (op_r == OP_PROGRAM) begin
							cycAddr = tgtAddr_r;
							cycData = tgtData_r;
						end else begin
							cycAddr = `UNLOCK_ADDR1;
							cycData = `UNLOCK_DATA1;
						end
					end
					3'd1, 3'd4: begin
						cycAddr = `UNLOCK_ADDR2;
						cycData = `UNLOCK_DATA2;
					end
					3'd2: begin
						cycAddr = `UNLOCK_ADDR1;
						case (op_r)
							OP_RESET: cycData = `CMD_RESET;
							OP_IDENT: cycData = `CMD_IDENT;
							OP_PROGRAM: cycData = `CMD_PROGRAM;
							default: cycData = `CMD_ERASE_SETUP;
						endcase
					end
					default: begin
						if (op_r == OP_CHIP_ERASE) begin
							cycAddr = `UNLOCK_ADDR1;
							cycData = `CMD_CHIP_ERASE;
						end else begin
							cycAddr = tgtAddr_r;
							cycData = `CMD_SECTOR_ERASE;
						end
					end
				endcase
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// Sequence control
	always_ff @(posedge clock) begin
		if (rst) begin
			// flash is in read mode at start
			state_r <= ST_IDLE;
			op_r <= OP_READ;
			step_r <= '0;
			tgtAddr_r <= '0;
			tgtData_r <= '0;
			cycStart_r <= 1'b0;
			cmdReady <= 1'b0;
		end else begin
			cycStart_r <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					cmdReady <= 1'b1;
					if (cmdValid && cmdReady) begin
						cmdReady <= 1'b0;
						op_r <= cmdOp;
						tgtAddr_r <= cmdAddr;
						tgtData_r <= cmdData;
						step_r <= '0;
						state_r <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					// Never start over a cycle still in flight
					if (!cycBusy) begin
						cycStart_r <= 1'b1;
						state_r <= ST_PULSE;
					end
				end
				ST_PULSE: begin
					if (cycDone) begin
						if (step_r == stepCount - 3'd1) begin
							state_r <= ST_IDLE;
						end else begin
							step_r <= step_r + 3'd1;
							state_r <= ST_NEXT;
						end
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Result and status decode on reads
	always_ff @(posedge clock) begin
		if (rst) begin
			resultValid <= 1'b0;
			resultData <= '0;
			opDone <= 1'b0;
			opFailed <= 1'b0;
		end else begin
			resultValid <= 1'b0;
			opDone <= 1'b0;
			if (state_r == ST_PULSE && cycDone
				&& step_r == stepCount - 3'd1) begin
				resultValid <= !cycWrite;
				resultData <= cycRdata;
				if (op_r == OP_POLL) begin
					// program done when bit 7 matches
					// erase done when bit 7 is one
					opDone <= cycRdata[`BIT_POLL] == tgtData_r[`BIT_POLL];
					opFailed <= cycRdata[`BIT_LIMIT]
						&& cycRdata[`BIT_POLL] != tgtData_r[`BIT_POLL];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	flash_bus_cycle flash_bus_cycle_inst (
		.clock(clock),
		.rst(rst),
		.start(cycStart_r),
		.isWrite(cycWrite),
		.addr(cycAddr),
		.wdata(cycData),
		.busy(cycBusy),
		.done(cycDone),
		.rdata(cycRdata),
		.chipEnableN(chipEnableN),
		.outputEnableN(outputEnableN),
		.writeEnableN(writeEnableN),
		.addrOut(flashAddr),
		.dataOut(flashDataOut),
		.dataOe(flashDataOe),
		.dataIn(flashDataIn)
	);
endmodule

// >>> hw/flash_host_consts.svh
// Constants for the flash command host controller
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH
`define ADDR_W 19
`define UNLOCK_ADDR1 19'h05555
`define UNLOCK_ADDR2 19'h02aaa
`define UNLOCK_DATA1 8'haa
`define UNLOCK_DATA2 8'h55
`define CMD_RESET 8'hf0
`define CMD_IDENT 8'h90
`define CMD_PROGRAM 8'ha0
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECTOR_ERASE 8'h30
`define CMD_SUSPEND 8'hb0
`define CMD_RESUME 8'h30
`define BIT_POLL 7
`define BIT_TOGGLE 6
`define BIT_LIMIT 5
`define BIT_TIMER 3
// Bus phase timing in 8 ns cycles
`define CLK_NS 8
`define SETUP_NS 16
`define PULSE_NS 56
`define HOLD_NS 24
`define ACCESS_NS 160
`define SETUP_CYC ((`SETUP_NS + `CLK_NS - 1) / `CLK_NS)
`define PULSE_CYC ((`PULSE_NS + `CLK_NS - 1) / `CLK_NS)
`define HOLD_CYC ((`HOLD_NS + `CLK_NS - 1) / `CLK_NS)
`define ACCESS_CYC ((`ACCESS_NS + `CLK_NS - 1) / `CLK_NS)
`define CNT_W 8
`endif

// >>> hw/flash_host_pkg.sv
// Types for the flash command host controller
package flash_host_pkg;
	typedef enum logic [3:0] {
		OP_READ = 4'h0,
		OP_RESET = 4'h1,
		OP_IDENT = 4'h2,
		OP_PROGRAM = 4'h3,
		OP_CHIP_ERASE = 4'h4,
		OP_SECTOR_ERASE = 4'h5,
		OP_ADD_SECTOR = 4'h6,
		OP_SUSPEND = 4'h7,
		OP_RESUME = 4'h8,
		OP_POLL = 4'h9,
		OP_SHORT_RESET = 4'ha
	} op_t;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_SETUP = 6'b000010,
		ST_PULSE = 6'b000100,
		ST_HOLD = 6'b001000,
		ST_NEXT = 6'b010000,
		ST_DONE = 6'b100000
	} state_t;
endpackage

// >>> hw/flash_bus_cycle.sv
// One timed bus cycle on the flash pins, read or write
`include "flash_host_consts.svh"
module flash_bus_cycle
	import flash_host_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Cycle request
	input wire logic start,
	input wire logic isWrite,
	input wire logic [`ADDR_W-1:0] addr,
	input wire logic [7:0] wdata,
	output logic busy,
	output logic done,
	output logic [7:0] rdata,
	// Flash pins
	output logic chipEnableN,
	output logic outputEnableN,
	output logic writeEnableN,
	output logic [`ADDR_W-1:0] addrOut,
	output logic [7:0] dataOut,
	output logic dataOe,
	input wire logic [7:0] dataIn
);
	state_t state_r;
	logic [`CNT_W-1:0] cnt_r;
	logic wr_r;

	always_ff @(posedge clock) begin
		if (rst) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			wr_r <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			addrOut <= '0;
			dataOut <= '0;
		end else begin
			done <= 1'b0;
			case (state_r)
				ST_IDLE: begin
					if (start) begin
						state_r <= ST_SETUP;
						cnt_r <= `CNT_W'(`SETUP_CYC);
						wr_r <= isWrite;
						busy <= 1'b1;
						addrOut <= addr;
						dataOut <= wdata;
					end
				end
				ST_SETUP: begin
					if (cnt_r == `CNT_W'(1)) begin
						state_r <= ST_PULSE;
						cnt_r <= wr_r ? `CNT_W'(`PULSE_CYC)
							: `CNT_W'(`ACCESS_CYC);
					end else begin
						cnt_r <= cnt_r - `CNT_W'(1);
					end
				end
				ST_PULSE: begin
					if (cnt_r == `CNT_W'(1)) begin
						state_r <= ST_HOLD;
						cnt_r <= `CNT_W'(`HOLD_CYC);
					end else begin
						cnt_r <= cnt_r - `CNT_W'(1);
					end
				end
				ST_HOLD: begin
					if (cnt_r == `CNT_W'(1)) begin
						state_r <= ST_IDLE;
						busy <= 1'b0;
						done <= 1'b1;
					end else begin
						cnt_r <= cnt_r - `CNT_W'(1);
					end
				end
				default: begin
					state_r <= ST_IDLE;
					busy <= 1'b0;
				end
			endcase
		end
	end

	// Strobes: CE across setup+pulse, WE or OE in pulse only
	always_ff @(posedge clock) begin
		if (rst) begin
			chipEnableN <= 1'b1;
			outputEnableN <= 1'b1;
			writeEnableN <= 1'b1;
			dataOe <= 1'b0;
		end else begin
			// addr before WE fall, data held past WE rise
			chipEnableN <= !(state_r == ST_SETUP || state_r == ST_PULSE);
			// OE high whenever WE is low
			writeEnableN <= !(state_r == ST_PULSE && wr_r);
			outputEnableN <= !(state_r == ST_PULSE && !wr_r);
			// host drives bus only on writes
			dataOe <= wr_r && (state_r == ST_SETUP || state_r == ST_PULSE
				|| state_r == ST_HOLD);
		end
	end

	// Sample read data at end of access
	always_ff @(posedge clock) begin
		if (rst) begin
			rdata <= '0;
		end else if (state_r == ST_PULSE && !wr_r && cnt_r == `CNT_W'(1)) begin
			rdata <= dataIn;
		end
	end
endmodule

// >>> sim/flash_model.sv
// Behavioural flash device on the far side of the host
module flash_model #(
	parameter int POLLS = 3
) (
	input wire logic chipEnableN,
	input wire logic outputEnableN,
	input wire logic writeEnableN,
	input wire logic [18:0] addr,
	input wire logic [7:0] din,
	output logic [7:0] dout
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [int];
	logic [18:0] latA = 19'h0;
	logic [7:0] rv = 8'hff;
	logic w7 = 1'b0, tg = 1'b0, wrOn = 1'b0;
	int step = 0, busy = 0;
	assign dout = (!chipEnableN && !outputEnableN && writeEnableN) ? rv : ~rv;
	task automatic erase_sec(logic [18:0] a);
		foreach (mem[k]) if (k[18:16] == a[18:16]) mem[k] = 8'hff;
	endtask
	task automatic take(logic [7:0] d);
		logic h5, h2;
		h5 = latA[14:0] == 15'h5555;
		h2 = latA[14:0] == 15'h2aaa;
		if (d == 8'hf0) begin
			step = 0;
			busy = 0;
		end else if (busy > 0) begin
			if (d == 8'h30) erase_sec(latA);
		end else
		case (step)
			0, 4: step = (h5 && d == 8'haa) ? step + 1 : 0;
			1, 5: step = (h2 && d == 8'h55) ? step + 1 : 0;
			2: step = !h5 ? 0 : d == 8'ha0 ? 3 : d == 8'h80 ? 4 : 0;
			3: begin
				mem[latA] = d;
				w7 = d[7];
				busy = POLLS;
				step = 0;
			end
			// erase busy count starts from the 10 write or the first 30 write
			6: begin
				if (h5 && d == 8'h10) foreach (mem[k]) mem[k] = 8'hff;
				if (d == 8'h30) erase_sec(latA);
				if ((h5 && d == 8'h10) || d == 8'h30) begin
					w7 = 1'b1;
					busy = POLLS;
				end
				step = 0;
			end
			default: step = 0;
		endcase
	endtask
	always @(negedge writeEnableN or negedge chipEnableN)
		if (!writeEnableN && !chipEnableN && outputEnableN) begin
			latA = addr;
			wrOn = 1'b1;
		end
	always @(posedge writeEnableN or posedge chipEnableN)
		if (wrOn) begin
			wrOn = 1'b0;
			take(din);
		end
	always @(negedge outputEnableN)
		if (!chipEnableN && busy > 0) begin
			tg = ~tg;
			rv = {~w7, tg, 6'h00};
			busy--;
		end else if (!chipEnableN)
			rv = mem.exists(addr) ? mem[addr] : 8'hff;
endmodule

// >>> sim/flash_command_sequencer_asserts.sv
// Pin and command-side protocol checks for the flash command sequencer
`include "flash_host_consts.svh"
module flash_command_sequencer_asserts (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Command side
	input wire logic cmdValid,
	input wire logic [7:0] cmdData,
	input wire logic cmdReady,
	input wire logic resultValid,
	input wire logic [7:0] resultData,
	input wire logic opDone,
	// Flash pins
	input wire logic chipEnableN,
	input wire logic outputEnableN,
	input wire logic writeEnableN,
	input wire logic [`ADDR_W-1:0] flashAddr,
	input wire logic [7:0] flashDataOut,
	input wire logic flashDataOe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic exp7_r;
	always_ff @(posedge clock) begin
		if (cmdValid && cmdReady)
			exp7_r <= cmdData[7];
	end
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	sequence weLow;
		!writeEnableN [*7] ##1 writeEnableN;
	endsequence
	a_write_qual:
		assert property (!writeEnableN |-> !chipEnableN && outputEnableN)
		else $error("write strobe without select");
	a_read_qual:
		assert property (!outputEnableN |->
			!chipEnableN && writeEnableN && !flashDataOe)
		else $error("bad read strobe");
	a_standby_idle:
		assert property (chipEnableN |-> outputEnableN && writeEnableN)
		else $error("strobe while deselected");
	a_pulse_width:
		assert property ($fell(writeEnableN) |-> weLow)
		else $error("write pulse length");
	a_data_steady:
		assert property (!writeEnableN && $past(!writeEnableN) |->
			$stable(flashDataOut) && $stable(flashAddr) && flashDataOe)
		else $error("bus moved in write pulse");
	a_data_hold:
		assert property ($rose(writeEnableN) |-> flashDataOe ##1 flashDataOe)
		else $error("data released at rise");
	a_one_op:
		assert property (cmdValid && cmdReady |=> !cmdReady [*8])
		else $error("ready during op");
	a_result_pulse:
		assert property (resultValid |=> !resultValid)
		else $error("result not a pulse");
	a_done_match:
		assert property (opDone |-> resultValid && resultData[7] == exp7_r)
		else $error("done without match");
endmodule
bind flash_command_sequencer flash_command_sequencer_asserts
	flash_command_sequencer_asserts_inst (.clock, .rst, .cmdValid,
	.cmdData, .cmdReady, .resultValid, .resultData, .opDone,
	.chipEnableN, .outputEnableN, .writeEnableN, .flashAddr,
	.flashDataOut, .flashDataOe);

// >>> sim/test_flash_command_sequencer.sv
// Self-checking bench for the flash command sequencer
module test_flash_command_sequencer
	import flash_host_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 0, rst = 1, cmdValid = 0, cmdReady, t;
	logic resultValid, opDone, opFailed, ceN, oeN, weN, fOe;
	op_t cmdOp = OP_READ;
	logic [18:0] cmdAddr = 19'h0, fAddr, a0;
	logic [7:0] cmdData = 8'h0, resultData, fOut, fIn, d;
	logic [31:0] seed = 32'h1708c8ac;
	logic [7:0] shadow [int];
	int bad_count = 0, num_checks = 0, n;
	initial forever #4 clock = ~clock;
	flash_command_sequencer flash_command_sequencer_inst (.clock, .rst,
		.cmdValid, .cmdOp, .cmdAddr, .cmdData, .cmdReady, .resultValid,
		.resultData, .opDone, .opFailed, .chipEnableN(ceN),
		.outputEnableN(oeN), .writeEnableN(weN), .flashAddr(fAddr),
		.flashDataOut(fOut), .flashDataOe(fOe), .flashDataIn(fIn));
	flash_model #(.POLLS(3)) flash_model_inst (.chipEnableN(ceN),
		.outputEnableN(oeN), .writeEnableN(weN), .addr(fAddr),
		.din(fOut), .dout(fIn));
	function automatic logic [31:0] lfsr(logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] at(logic [18:0] a);
		return shadow.exists(a) ? shadow[a] : 8'hff;
	endfunction
	task automatic check(string what, logic [7:0] seen, logic [7:0] want);
		num_checks++;
		if (seen !== want) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic run(op_t op, logic [18:0] a, logic [7:0] dv);
		n = 0;
		do @(negedge clock); while (cmdReady !== 1'b1 && ++n < 400);
		@(posedge clock);
		cmdOp <= op;
		cmdAddr <= a;
		cmdData <= dv;
		cmdValid <= 1'b1;
		@(posedge clock);
		cmdValid <= 1'b0;
		do @(negedge clock);
		while (resultValid !== 1'b1 && cmdReady !== 1'b1 && ++n < 400);
		if (n >= 400) begin
			bad_count++;
			close_out();
		end
	endtask
	task automatic poll(logic [18:0] a, logic [7:0] dv);
		int k;
		k = 0;
		do begin
			run(OP_POLL, a, dv);
			k++;
			if (k == 1) check("busy bit7", resultData[7], {7'h0, ~dv[7]});
			if (k == 1) t = resultData[6];
			if (k == 2) check("toggle", resultData[6], {7'h0, ~t});
		end while (opDone !== 1'b1 && k < 9);
		check("poll count", 8'(k), 8'h04);
		check("no failure", {7'h0, opFailed}, 8'h00);
	endtask
	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		run(OP_READ, 19'h7ffff, 8'h00);
		check("read after reset", resultData, 8'hff);
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			seed = lfsr(seed);
			a0 = seed[18:0];
			d = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[26:19];
			run(OP_PROGRAM, a0, d);
			poll(a0, d);
			shadow[a0] = d;
			run(OP_READ, a0, 8'h00);
			check("program readback", resultData, at(a0));
		end
		$display("test program done");
		run(OP_IDENT, a0, 8'h00);
		run(OP_SHORT_RESET, a0, 8'h00);
		run(OP_IDENT, a0, 8'h00);
		run(OP_RESET, a0, 8'h00);
		run(OP_READ, a0, 8'h00);
		check("read after reset cmd", resultData, at(a0));
		$display("test reset commands done");
		run(OP_SECTOR_ERASE, a0, 8'h00);
		run(OP_ADD_SECTOR, a0 ^ 19'h40000, 8'h00);
		run(OP_SUSPEND, a0, 8'h00);
		run(OP_RESUME, a0, 8'h00);
		poll(a0, 8'h80);
		foreach (shadow[k])
			if (k[17:16] == a0[17:16]) shadow[k] = 8'hff;
		foreach (shadow[k]) begin
			run(OP_READ, 19'(k), 8'h00);
			check("sector erase", resultData, shadow[k]);
		end
		$display("test sector erase done");
		run(OP_CHIP_ERASE, a0, 8'h00);
		poll(a0, 8'h80);
		run(OP_READ, a0, 8'h00);
		check("chip erase", resultData, 8'hff);
		$display("test chip erase done");
		close_out();
	end
endmodule
